// *** uic_ctrl.sv ***
// Interrupt enable, source identification and queue control of the serial port
// --------------------------------------------------------------------------
// Top level
// --------------------------------------------------------------------------
// How it works
// - Low four enable bits; all zero means none
// - Sources keep recording regardless of enables
// - Bit zero enables received data and time-out
// - Bit one enables transmit holding empty
// - Bit two enables line error interrupt
// - Bit three enables modem change interrupt
// - Reserved bits ignore writes, read zero
// - Priority: line, receive, transmit, modem
// - Identification frozen while host reads it
// - Bit zero low means interrupt pending
// - Identification codes per source as listed
// - Bit three only with queue time-out
// - Bits seven and six mirror queue enable
// - Receive interrupt follows occupancy versus trigger when queue enabled, data ready otherwise
// - Time-out after four idle character times
// - Transmit empty clears on ident read or write
// - Queue control write-only at ident offset
// - Enable bit zero; clearing flushes both queues
// - Receive flush bit self-clears, pulses flush
// - Transmit flush bit self-clears, pulses flush
// - Trigger select: one, four, eight, fourteen
// - Interrupt output driven only when gate set
module uic_ctrl
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_nrst,
  input  wire logic              i_ce,
  input  uic_pkg::uic_bus_t      i_bus,
  input  wire logic              i_divisor_access_select,
  input  wire logic              i_irq_output_gate,
  input  uic_pkg::uic_evt_t      i_evt,
  output logic [7:0]             o_reg_rdata,
  output logic                   o_fifo_enable,
  output logic [4:0]             o_rx_trigger,
  output logic                   o_rx_flush,
  output logic                   o_tx_flush,
  output logic                   o_irq,
  output logic                   o_irq_oe
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [3:0] ier_q;
  logic       fifo_en_q;
  logic [1:0] trig_sel_q;
  logic       rx_flush_q;
  logic       tx_flush_q;
  logic [7:0] ident_q;
  logic [7:0] ident_d;
  logic [3:0] id_code;
  logic [7:0] rdata_q;
  logic       rd_q;
  logic       iir_acc_q;
  logic       irq_q;
  logic [4:0] trig_lvl;
  logic       iir_access;
  logic       iir_end;
  logic       rd_rise;
  logic       data_sel;
  logic       tx_write;
  logic       rx_read;
  logic       ier_write;
  logic       qc_write;
  logic       line_flag;
  logic       modem_flag;
  logic       thre_flag;
  logic       thre_clr;
  logic       timeout_flag;
  logic       rx_avail;
  logic       line_pend;
  logic       rx_pend;
  logic       to_pend;
  logic       thre_pend;
  logic       modem_pend;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------

  // Access qualifiers; data and enable offsets need the divisor latch closed
  assign data_sel   = !i_divisor_access_select;
  assign iir_access = i_bus.rd && (i_bus.addr == uic_pkg::ADDR_IIR);
  assign rd_rise    = i_bus.rd && !rd_q;
  assign iir_end    = iir_acc_q && !iir_access;
  assign tx_write   = i_bus.wr && (i_bus.addr == uic_pkg::ADDR_DATA) && data_sel;
  assign rx_read    = rd_rise && (i_bus.addr == uic_pkg::ADDR_DATA) && data_sel;
  assign ier_write  = i_bus.wr && (i_bus.addr == uic_pkg::ADDR_IER) && data_sel;
  assign qc_write   = i_bus.wr && (i_bus.addr == uic_pkg::ADDR_IIR);

  // Read access tracking for edges
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rd_q      <= 1'b0;
      iir_acc_q <= 1'b0;
    end
    else if (i_ce)
    begin
      rd_q      <= i_bus.rd;
      iir_acc_q <= iir_access;
    end
  end

  // --------------------------------------------------------------------------
  // Enable register
  // --------------------------------------------------------------------------

  // Only the low nibble is stored; the upper nibble has no storage
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      ier_q <= uic_pkg::IER_RESET;
    else if (i_ce && ier_write)
      ier_q <= i_bus.wdata[3:0];
  end

  // --------------------------------------------------------------------------
  // Queue control register
  // --------------------------------------------------------------------------

  // Enable and trigger select; trigger select only loads when the write sets enable
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      fifo_en_q  <= 1'b0;
      trig_sel_q <= uic_pkg::TRIG_RESET;
    end
    else if (i_ce && qc_write)
    begin
      fifo_en_q <= i_bus.wdata[uic_pkg::QC_ENABLE];
      if (i_bus.wdata[uic_pkg::QC_ENABLE])
        trig_sel_q <= i_bus.wdata[uic_pkg::QC_TRIG_HI:uic_pkg::QC_TRIG_LO];
    end
  end

  // Flush pulses; the flush bits are not held, each one pulses for a single cycle
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rx_flush_q <= 1'b0;
      tx_flush_q <= 1'b0;
    end
    else if (i_ce)
    begin
      rx_flush_q <= qc_write && (i_bus.wdata[uic_pkg::QC_RX_FLUSH]
                    || !i_bus.wdata[uic_pkg::QC_ENABLE]);
      tx_flush_q <= qc_write && (i_bus.wdata[uic_pkg::QC_TX_FLUSH]
                    || !i_bus.wdata[uic_pkg::QC_ENABLE]);
    end
  end

  // Trigger level decode
  always_comb
  begin
    unique case (trig_sel_q)
      2'h0: trig_lvl = uic_pkg::TRIG_LVL_1;
      2'h1: trig_lvl = uic_pkg::TRIG_LVL_4;
      2'h2: trig_lvl = uic_pkg::TRIG_LVL_8;
      2'h3: trig_lvl = uic_pkg::TRIG_LVL_14;
    endcase
  end

  // --------------------------------------------------------------------------
  // Interrupt sources
  // --------------------------------------------------------------------------

  // Line error source, cleared by a line status read
  uic_sticky u_line
  (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_set     (i_evt.line_err),
    .i_clr     (rd_rise && (i_bus.addr == uic_pkg::ADDR_LSR)),
    .o_flag    (line_flag)
  );

  // Modem change source, cleared by a modem status read
  uic_sticky u_modem
  (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_set     (i_evt.modem_delta),
    .i_clr     (rd_rise && (i_bus.addr == uic_pkg::ADDR_MSR)),
    .o_flag    (modem_flag)
  );

  // Transmit empty clears on a holding write or at the end of an ident read
  // that reported it
  assign thre_clr = tx_write || (iir_end && ident_q[3:0] == uic_pkg::ID_TX_EMPT);

  uic_sticky u_thre
  (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_ce      (i_ce),
    .i_set     (i_evt.tx_empty_set),
    .i_clr     (thre_clr),
    .o_flag    (thre_flag)
  );

  // Character time-out, a receive buffer read counts as activity
  uic_char_timeout u_tout
  (
    .i_clk_sys  (i_clk_sys),
    .i_nrst     (i_nrst),
    .i_ce       (i_ce),
    .i_fifo_en  (fifo_en_q),
    .i_nonempty (i_evt.rx_count != 5'h00),
    .i_activity (i_evt.rx_push || rx_read),
    .i_tick     (i_evt.char_tick),
    .o_timeout  (timeout_flag)
  );

  // Received data follows occupancy against the trigger, or data ready
  assign rx_avail = fifo_en_q ? (i_evt.rx_count >= trig_lvl)
                              : (i_evt.rx_count != 5'h00);

  // Gate sources with their enables; the sources themselves keep running
  assign line_pend  = line_flag    && ier_q[uic_pkg::IER_LINE_ERR];
  assign rx_pend    = rx_avail     && ier_q[uic_pkg::IER_RX_AVAIL];
  assign to_pend    = timeout_flag && fifo_en_q && ier_q[uic_pkg::IER_RX_AVAIL];
  assign thre_pend  = thre_flag    && ier_q[uic_pkg::IER_TX_EMPTY];
  assign modem_pend = modem_flag   && ier_q[uic_pkg::IER_MODEM];

  // --------------------------------------------------------------------------
  // Identification
  // --------------------------------------------------------------------------

  // Priority encoder, highest first
  always_comb
  begin
    if (line_pend)
      id_code = uic_pkg::ID_LINE;
    else if (rx_pend)
      id_code = uic_pkg::ID_RX_DATA;
    else if (to_pend)
      id_code = uic_pkg::ID_TIMEOUT;
    else if (thre_pend)
      id_code = uic_pkg::ID_TX_EMPT;
    else if (modem_pend)
      id_code = uic_pkg::ID_MODEM;
    else
      id_code = uic_pkg::ID_NONE;
  end

  // Queue-enabled mirror on top, reserved bits zero
  assign ident_d = {fifo_en_q, fifo_en_q, 2'b00, id_code};

  // Snapshot held while the host is reading it
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      ident_q <= uic_pkg::IDENT_RESET;
    else if (i_ce && !iir_access)
      ident_q <= ident_d;
  end

  // --------------------------------------------------------------------------
  // Read data and interrupt output
  // --------------------------------------------------------------------------

  // Registered read data; offsets owned elsewhere read zero here
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      rdata_q <= 8'h00;
    else if (i_ce && i_bus.rd)
    begin
      if (i_bus.addr == uic_pkg::ADDR_IER && data_sel)
        rdata_q <= {4'h0, ier_q};
      else if (i_bus.addr == uic_pkg::ADDR_IIR)
        rdata_q <= ident_q;
      else
        rdata_q <= 8'h00;
    end
  end

  // Interrupt level, driven only while the output gate is set
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      irq_q <= 1'b0;
    else if (i_ce)
      irq_q <= (id_code != uic_pkg::ID_NONE) && i_irq_output_gate;
  end

  assign o_reg_rdata   = rdata_q;
  assign o_fifo_enable = fifo_en_q;
  assign o_rx_trigger  = trig_lvl;
  assign o_rx_flush    = rx_flush_q;
  assign o_tx_flush    = tx_flush_q;
  assign o_irq         = irq_q;
  assign o_irq_oe      = i_irq_output_gate;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------

  ier_mask_zero_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && ier_q == 4'h0 && !iir_access |=> ident_q[3:0] == uic_pkg::ID_NONE)
    else $error("Interrupt reported with all enables clear");

  ier_upper_zero_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && i_bus.rd && i_bus.addr == uic_pkg::ADDR_IER |=> o_reg_rdata[7:4] == 4'h0)
    else $error("Enable register upper bits not zero");

  ident_freeze_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    iir_access && $past(iir_access) |-> $stable(ident_q))
    else $error("Identification changed during host read");

  fifo_mirror_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && !iir_access |=> ident_q[7:6] == {2{$past(fifo_en_q)}})
    else $error("Queue enabled bits wrong");

  line_priority_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && line_pend && !iir_access |=> ident_q[3:0] == uic_pkg::ID_LINE)
    else $error("Line error not reported first");

  rx_flush_pulse_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && qc_write && i_bus.wdata[1:0] == 2'h3 ##1 i_ce && !qc_write
    |-> o_rx_flush ##1 !o_rx_flush)
    else $error("Receive flush not a single pulse");

  fifo_disable_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && qc_write && !i_bus.wdata[0] |=> !fifo_en_q && o_rx_flush && o_tx_flush)
    else $error("Queue disable did not flush both sides");

  irq_gate_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && !i_irq_output_gate |=> !o_irq)
    else $error("Interrupt driven while gate clear");

  thre_clear_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_ce && tx_write && !i_evt.tx_empty_set |=> !thre_flag)
    else $error("Transmit empty not cleared by write");

  timeout_fifo_a: assert property (
    @(posedge i_clk_sys) disable iff (!i_nrst)
    ident_q[3] |-> ident_q[7] && ident_q[2:0] == 3'h4)
    else $error("Time-out bit outside queue mode");

endmodule : uic_ctrl

// *** uic_pkg.sv ***
// Shared constants and carrier types for the UART interrupt and queue control block
package uic_pkg;

  // --------------------------------------------------------------------------
  // Register offsets within the port window
  // --------------------------------------------------------------------------
  localparam logic [2:0] ADDR_DATA  = 3'h0;  // Receive buffer read, transmit holding write
  localparam logic [2:0] ADDR_IER   = 3'h1;  // irq_enable_mask
  localparam logic [2:0] ADDR_IIR   = 3'h2;  // irq_source_ident read, queue_control write
  localparam logic [2:0] ADDR_LSR   = 3'h5;  // Line status, read clears line error source
  localparam logic [2:0] ADDR_MSR   = 3'h6;  // Modem status, read clears modem source

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int IER_RX_AVAIL   = 0;  // rx_avail_irq_en
  localparam int IER_TX_EMPTY   = 1;  // tx_empty_irq_en
  localparam int IER_LINE_ERR   = 2;  // line_err_irq_en
  localparam int IER_MODEM      = 3;  // modem_change_irq_en
  localparam int QC_ENABLE      = 0;  // Queue enable
  localparam int QC_RX_FLUSH    = 1;  // receive_side flush
  localparam int QC_TX_FLUSH    = 2;  // transmit_side flush
  localparam int QC_TRIG_LO     = 6;  // Trigger select, low bit
  localparam int QC_TRIG_HI     = 7;  // Trigger select, high bit

  // --------------------------------------------------------------------------
  // Identification codes, bits 3 down to 0
  // --------------------------------------------------------------------------
  localparam logic [3:0] ID_NONE    = 4'h1;
  localparam logic [3:0] ID_LINE    = 4'h6;
  localparam logic [3:0] ID_RX_DATA = 4'h4;
  localparam logic [3:0] ID_TIMEOUT = 4'hc;
  localparam logic [3:0] ID_TX_EMPT = 4'h2;
  localparam logic [3:0] ID_MODEM   = 4'h0;

  // --------------------------------------------------------------------------
  // Reset values and counts
  // --------------------------------------------------------------------------
  localparam logic [3:0] IER_RESET   = 4'h0;
  localparam logic [1:0] TRIG_RESET  = 2'h0;
  localparam logic [7:0] IDENT_RESET = 8'h01;
  localparam logic [2:0] TIMEOUT_CHARS = 3'h4;  // Idle character times before time-out

  // Receive trigger levels in bytes
  localparam logic [4:0] TRIG_LVL_1  = 5'h01;
  localparam logic [4:0] TRIG_LVL_4  = 5'h04;
  localparam logic [4:0] TRIG_LVL_8  = 5'h08;
  localparam logic [4:0] TRIG_LVL_14 = 5'h0e;

  // --------------------------------------------------------------------------
  // Carrier types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic       rd;     // Read access, level for the access duration
    logic       wr;     // Write strobe, one cycle
    logic [2:0] addr;   // Register offset
    logic [7:0] wdata;  // Write data
  } uic_bus_t;

  typedef struct packed {
    logic       line_err;      // Pulse: overrun, parity, framing or break seen
    logic       modem_delta;   // Pulse: a modem change indicator changed
    logic       tx_empty_set;  // Pulse: transmit holding register became empty
    logic       rx_push;       // Pulse: character added to receive side
    logic       char_tick;     // Pulse: one character time elapsed
    logic [4:0] rx_count;      // Characters held by receive side
  } uic_evt_t;

endpackage : uic_pkg

// *** uic_sticky.sv ***
// Sticky event flag where a set in the clearing cycle wins
module uic_sticky
(
  input  wire logic i_clk_sys,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  input  wire logic i_set,
  input  wire logic i_clr,
  output logic      o_flag
);

  logic flag_q;

  // Set has priority over clear
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      flag_q <= 1'b0;
    else if (i_ce)
      flag_q <= i_set | (flag_q & ~i_clr);
  end

  assign o_flag = flag_q;

endmodule : uic_sticky

// *** uic_char_timeout.sv ***
// Receive character time-out detector
module uic_char_timeout
(
  input  wire logic i_clk_sys,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  input  wire logic i_fifo_en,
  input  wire logic i_nonempty,
  input  wire logic i_activity,
  input  wire logic i_tick,
  output logic      o_timeout
);

  logic [2:0] idle_q;

  // Count idle character times, restart on any add or remove
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
      idle_q <= 3'h0;
    else if (i_ce)
    begin
      if (!i_fifo_en || !i_nonempty || i_activity)
        idle_q <= 3'h0;
      else if (i_tick && idle_q != uic_pkg::TIMEOUT_CHARS)
        idle_q <= idle_q + 3'h1;
    end
  end

  assign o_timeout = (idle_q == uic_pkg::TIMEOUT_CHARS);

endmodule : uic_char_timeout

// *** uic_host_model.sv ***
// Host processor model driving the serial port register bus
module uic_host_model
(
  input  wire logic         i_clk_sys,
  input  wire logic [7:0]   i_reg_rdata,
  output uic_pkg::uic_bus_t o_bus,
  output logic              o_divisor_access_select,
  output logic              o_irq_output_gate
);
  timeunit 1ns;
  timeprecision 100ps;

  // ---------------------------------------------------------------
  // Idle bus from time zero
  // ---------------------------------------------------------------
  initial
  begin
    o_bus = '0;
    o_divisor_access_select = 1'b0;
    o_irq_output_gate = 1'b1;
  end

  // Byte write with a one-cycle strobe; released fields are scrambled
  task automatic write(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    #1;
    o_bus.addr = a;
    o_bus.wdata = d;
    o_bus.wr = 1'b1;
    @(posedge i_clk_sys);
    #1;
    o_bus.wr = 1'b0;
    o_bus.addr = ~a;
    o_bus.wdata = ~d;
  endtask : write

  // Raise a read access and keep it held
  task automatic rd_begin(input logic [2:0] a);
    @(posedge i_clk_sys);
    #1;
    o_bus.addr = a;
    o_bus.rd = 1'b1;
  endtask : rd_begin

  // Take the answer at the next edge, then release the access
  task automatic rd_end(output logic [7:0] d);
    @(posedge i_clk_sys);
    #1;
    d = i_reg_rdata;
    o_bus.rd = 1'b0;
    o_bus.addr = ~o_bus.addr;
  endtask : rd_end

  // Single-cycle read; ident and control share offset two
  task automatic read(input logic [2:0] a, output logic [7:0] d);
    rd_begin(a);
    rd_end(d);
  endtask : read

  // Divisor access select, kept low for enable accesses by default
  task automatic set_divisor_access_select(input logic v);
    @(posedge i_clk_sys);
    #1;
    o_divisor_access_select = v;
  endtask : set_divisor_access_select

  // Interrupt output gate level
  task automatic set_gate(input logic v);
    @(posedge i_clk_sys);
    #1;
    o_irq_output_gate = v;
  endtask : set_gate
endmodule : uic_host_model

// *** uic_ctrl_bench.sv ***
// Self-checking bench for the interrupt and queue control block
module uic_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [4:0] LE = 5'h10;
  localparam logic [4:0] MD = 5'h08;
  localparam logic [4:0] TE = 5'h04;
  localparam logic [4:0] PU = 5'h02;
  localparam logic [4:0] TK = 5'h01;

  logic              clk;
  logic              nrst;
  logic              ce;
  logic [4:0]        pv;
  logic [4:0]        cnt;
  logic [7:0]        d;
  int                fail_count;
  int                n_compared;
  uic_pkg::uic_bus_t bus;
  uic_pkg::uic_evt_t evt;
  logic              divisor_access_select;
  logic              gate;
  logic [7:0]        rdata;
  logic              fen;
  logic [4:0]        trig;
  logic              rxf;
  logic              txf;
  logic              irq;
  logic              irq_oe;

  assign evt = {pv, cnt};

  // ---------------------------------------------------------------
  // Design and host model
  // ---------------------------------------------------------------
  uic_ctrl DUT
  (
    .i_clk_sys               (clk),
    .i_nrst                  (nrst),
    .i_ce                    (ce),
    .i_bus                   (bus),
    .i_divisor_access_select (divisor_access_select),
    .i_irq_output_gate       (gate),
    .i_evt                   (evt),
    .o_reg_rdata             (rdata),
    .o_fifo_enable           (fen),
    .o_rx_trigger            (trig),
    .o_rx_flush              (rxf),
    .o_tx_flush              (txf),
    .o_irq                   (irq),
    .o_irq_oe                (irq_oe)
  );

  uic_host_model host
  (
    .i_clk_sys               (clk),
    .i_reg_rdata             (rdata),
    .o_bus                   (bus),
    .o_divisor_access_select (divisor_access_select),
    .o_irq_output_gate       (gate)
  );

  // Clock at 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      fail_count++;
    end
  endtask : chk

  // Idle one edge so pending state settles, then read and compare
  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] v;
    @(posedge clk);
    host.read(a, v);
    chk(v, e);
  endtask : rdchk

  // One-cycle event pulse from the line side
  task automatic pulse(input logic [4:0] p);
    @(posedge clk);
    #1;
    pv = p;
    @(posedge clk);
    #1;
    pv = '0;
  endtask : pulse

  // Queue control write, then flush pulses must be gone a cycle later
  task automatic qc(input logic [7:0] w, input logic [7:0] e);
    host.write(3'h2, w);
    chk({rxf, txf, fen, trig}, e);
    @(posedge clk);
    #1;
    chk({6'h00, rxf, txf}, 8'h00);
  endtask : qc

  // Counts and verdict
  task automatic results();
    $display("compared=%0d mismatches=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // Watchdog well beyond the expected run of under two hundred cycles
  initial
  begin
    #40000;
    fail_count++;
    results();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    fail_count = 0;
    n_compared = 0;
    nrst = 1'b0;
    ce = 1'b1;
    pv = '0;
    cnt = '0;
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    rdchk(3'h1, 8'h00);
    rdchk(3'h2, 8'h01);
    chk({7'h00, irq}, 8'h00);
    host.write(3'h1, 8'hf0);
    rdchk(3'h1, 8'h00);
    // Disabled source still records, shows once enabled
    pulse(LE);
    rdchk(3'h2, 8'h01);
    chk({7'h00, irq}, 8'h00);
    host.write(3'h1, 8'h04);
    rdchk(3'h2, 8'h06);
    chk({6'h00, irq_oe, irq}, 8'h03);
    host.set_gate(1'b0);
    @(posedge clk);
    #1;
    chk({6'h00, irq_oe, irq}, 8'h00);
    host.set_gate(1'b1);
    host.read(3'h5, d);
    rdchk(3'h2, 8'h01);
    // Priority walk down all four sources
    host.write(3'h1, 8'hff);
    cnt = 5'h01;
    pulse(LE | MD | TE);
    rdchk(3'h2, 8'h06);
    host.read(3'h5, d);
    rdchk(3'h2, 8'h04);
    cnt = 5'h00;
    rdchk(3'h2, 8'h02);
    rdchk(3'h2, 8'h00);
    host.read(3'h6, d);
    rdchk(3'h2, 8'h01);
    // Transmit empty cleared by a holding write
    pulse(TE);
    @(posedge clk);
    #1;
    chk({7'h00, irq}, 8'h01);
    host.write(3'h0, 8'h5a);
    rdchk(3'h2, 8'h01);
    // Ident frozen while the host holds the read
    host.rd_begin(3'h2);
    pulse(MD);
    host.rd_end(d);
    chk(d, 8'h01);
    rdchk(3'h2, 8'h00);
    host.read(3'h6, d);
    // Queue control: flushes, enable, trigger levels
    qc(8'h03, 8'ha1);
    qc(8'h45, 8'h64);
    qc(8'h81, 8'h28);
    qc(8'hc1, 8'h2e);
    rdchk(3'h2, 8'hc1);
    qc(8'h40, 8'hce);
    rdchk(3'h2, 8'h01);
    qc(8'h41, 8'h24);
    cnt = 5'h04;
    rdchk(3'h2, 8'hc4);
    cnt = 5'h03;
    rdchk(3'h2, 8'hc1);
    // Character time-out after four idle character times
    pulse(PU);
    repeat (3) pulse(TK);
    rdchk(3'h2, 8'hc1);
    pulse(TK);
    rdchk(3'h2, 8'hcc);
    host.read(3'h0, d);
    rdchk(3'h2, 8'hc1);
    // Enable register hidden while divisor access is selected
    host.set_divisor_access_select(1'b1);
    host.write(3'h1, 8'h00);
    rdchk(3'h1, 8'h00);
    host.set_divisor_access_select(1'b0);
    rdchk(3'h1, 8'h0f);
    // Clock enable low freezes the enable register against a write
    ce = 1'b0;
    host.write(3'h1, 8'h00);
    ce = 1'b1;
    rdchk(3'h1, 8'h0f);
    rdchk(3'h7, 8'h00);
    results();
  end
endmodule : uic_ctrl_bench
